// ### dv/nvsram_host_sva.sv
// checker on the host controller ports
// assumes one clock domain and the shortened boot count passed by bind
`default_nettype none
module nvsram_host_sva #(
    parameter int unsigned POWERUP_CYC = 50
) (
    input wire logic                       CLK_SYS_I,
    input wire logic                       RST_I,
    input wire logic                       CMD_VALID_I,
    input wire nvsram_host_pkg::cmd_s      CMD_I,
    input wire logic                       CMD_READY_O,
    input wire logic                       NV_BUSY_O,
    input wire logic                       DIRTY_O,
    input wire nvsram_host_pkg::mem_pins_s MEM_O,
    input wire logic                       HSB_N_I,
    input wire logic                       HSB_N_O,
    input wire logic                       HSB_N_OE_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    logic [31:0] up_cnt;
    logic        take;
    assign take = CMD_VALID_I && CMD_READY_O;
    // cycles since reset, saturating so it never wraps
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) up_cnt <= 32'h0000_0000;
        else if (up_cnt != 32'hFFFF_FFFF) up_cnt <= up_cnt + 32'h0000_0001;
    end
    AST_WE_HIGH_IN_READ: assert property (!MEM_O.oe_n |-> MEM_O.we_n && !MEM_O.dq_oe)
        else $error("write enable or dq drive during read");
    AST_SAVE_LINE_FREE: assert property (!HSB_N_OE_O && HSB_N_O)
        else $error("host drives the save line");
    AST_READ_HOLD: assert property ($fell(MEM_O.ce_n) && !MEM_O.oe_n |=>
        (!MEM_O.ce_n && $stable(MEM_O.addr)) [*8]) else $error("read select too short");
    AST_SELECT_GAP: assert property ($rose(MEM_O.ce_n) |-> MEM_O.ce_n [*2])
        else $error("select gap too short");
    AST_BUSY_BLOCKS: assert property (NV_BUSY_O [*2] |-> !CMD_READY_O)
        else $error("ready while busy");
    AST_SAVE_LINE_BLOCKS: assert property (!HSB_N_I [*7] |-> !CMD_READY_O)
        else $error("ready while save line low");
    AST_BOOT_WAIT: assert property (CMD_READY_O |-> up_cnt >= POWERUP_CYC)
        else $error("ready before boot wait");
    AST_WRITE_DIRTY: assert property (take && CMD_I.op == nvsram_host_pkg::OP_WRITE
        |-> ##[1:12] DIRTY_O) else $error("write not marked dirty");
    // main scenarios reached
    COV_READ: cover property (take && CMD_I.op == nvsram_host_pkg::OP_READ);
    COV_SAVE: cover property (take && CMD_I.op == nvsram_host_pkg::OP_SAVE && DIRTY_O);
    COV_LINE: cover property (!HSB_N_I && NV_BUSY_O);
    COV_RESTORE: cover property (take && CMD_I.op == nvsram_host_pkg::OP_RESTORE);
endmodule // nvsram_host_sva
bind nvsram_host nvsram_host_sva #(.POWERUP_CYC(POWERUP_CYC)) chk_u (
    .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .CMD_VALID_I(CMD_VALID_I), .CMD_I(CMD_I),
    .CMD_READY_O(CMD_READY_O), .NV_BUSY_O(NV_BUSY_O), .DIRTY_O(DIRTY_O), .MEM_O(MEM_O),
    .HSB_N_I(HSB_N_I), .HSB_N_O(HSB_N_O), .HSB_N_OE_O(HSB_N_OE_O));
`default_nettype wire

// ### dv/nvsram_mem_model.sv
// behavioural byte-wide nvsram facing the host controller
// assumes pins come straight from the host; the save line is held by the bench
`default_nettype none
module nvsram_mem_model (
    input  wire nvsram_host_pkg::mem_pins_s pins_i,
    input  wire logic                       save_n_i,
    output var  logic [7:0]                 dq_o,
    output var  logic [5:0][16:0]           seq_log_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    logic [7:0] last;
    // known contents, so a released bus never reads unknown
    initial begin
        foreach (mem[i]) mem[i] = 8'(i);
        last = 8'h00;
        seq_log_o = '0;
    end
    // drive only while selected and not saving
    always_comb begin
        if (!pins_i.ce_n && !pins_i.oe_n && pins_i.we_n && save_n_i) dq_o = mem[pins_i.addr[7:0]];
        else dq_o = ~last;
    end
    // released bus shows the inverse of the last byte
    always @(posedge pins_i.ce_n) last = mem[pins_i.addr[7:0]];
    always @(pins_i) begin
        if (!pins_i.ce_n && !pins_i.we_n && pins_i.dq_oe && save_n_i) mem[pins_i.addr[7:0]] = pins_i.dq;
    end
    always @(negedge pins_i.ce_n) begin
        if (!pins_i.oe_n && pins_i.we_n) seq_log_o = {pins_i.addr, seq_log_o[5:1]};
    end
endmodule // nvsram_mem_model
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the nvsram host controller
// assumes shortened wait counts; the save line has a pull-up
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P_UP = 50, P_SAVE = 40, P_RES = 20, P_SEQ = 10;
    logic clk = 1'b0, rst = 1'b1, cmd_v = 1'b0, save_n = 1'b1;
    nvsram_host_pkg::cmd_s cmd = '0;
    nvsram_host_pkg::mem_pins_s pins;
    logic rdy, rd_v, busy, dirty, hsb_o, hsb_oe, hsb_line;
    logic [7:0] rd_d, dq;
    logic [5:0][16:0] seq_log;
    int n_errors = 0, check_count = 0, c;
    // pulled-up line, low only when someone drives it low
    assign hsb_line = hsb_oe ? hsb_o : save_n;
    nvsram_host #(.POWERUP_CYC(P_UP), .SAVE_CYC(P_SAVE), .RESTORE_CYC(P_RES),
        .SOFTSEQ_CYC(P_SEQ)) dut_u (.CLK_SYS_I(clk), .RST_I(rst), .CMD_VALID_I(cmd_v),
        .CMD_I(cmd), .CMD_READY_O(rdy), .RD_DATA_O(rd_d), .RD_VALID_O(rd_v), .NV_BUSY_O(busy),
        .DIRTY_O(dirty), .MEM_O(pins), .MEM_DQ_I(dq), .HSB_N_I(hsb_line), .HSB_N_O(hsb_o),
        .HSB_N_OE_O(hsb_oe));
    nvsram_mem_model model_u (.pins_i(pins), .save_n_i(save_n), .dq_o(dq), .seq_log_o(seq_log));
    initial forever #4 clk = ~clk;
    task automatic conclude();
        if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic timeout();
        n_errors++;
        conclude();
    endtask
    task automatic chk1(string nm, logic e, logic g);
        check_count++;
        if (g !== e) begin n_errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end
    endtask
    task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin n_errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end
    endtask
    task automatic chkw(string nm, logic [101:0] e, logic [101:0] g);
        check_count++;
        if (g !== e) begin n_errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end
    endtask
    // request held until an edge that sees ready high
    task automatic send(nvsram_host_pkg::op_e op, logic [16:0] a, logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cmd_v <= 1'b1;
        cmd <= '{op: op, addr: a, wdata: d};
        do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 5000);
        cmd_v <= 1'b0;
        if (n >= 5000) timeout();
    endtask
    task automatic rd_chk(logic [16:0] a, logic [7:0] e);
        int n;
        send(nvsram_host_pkg::OP_READ, a, 8'h00);
        n = 0;
        do begin @(posedge clk); n++; end while (rd_v !== 1'b1 && n < 40);
        if (n >= 40) timeout();
        chk8("rd_data", e, rd_d);
    endtask
    // soft op, counting busy cycles until ready again
    task automatic nv_op(nvsram_host_pkg::op_e op, output int cnt);
        int n;
        send(op, 17'h0_0000, 8'h00);
        n = 0;
        cnt = 0;
        do begin @(posedge clk); n++; cnt += int'(busy === 1'b1); end
        while (rdy !== 1'b1 && n < 1000);
        if (n >= 1000) timeout();
    endtask
    task automatic t_boot();
        int n;
        n = 0;
        do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 500);
        if (n >= 500) timeout();
        chk1("boot_wait", 1'b1, n >= P_UP);
    endtask
    task automatic t_rw();
        send(nvsram_host_pkg::OP_WRITE, 17'h0_0012, 8'h5A);
        send(nvsram_host_pkg::OP_WRITE, 17'h0_0013, 8'hC3);
        rd_chk(17'h0_0012, 8'h5A);
        rd_chk(17'h0_0013, 8'hC3);
        chk1("dirty", 1'b1, dirty);
    endtask
    task automatic t_save();
        nv_op(nvsram_host_pkg::OP_SAVE, c);
        chkw("save_seq", nvsram_host_pkg::STORE_SEQ, seq_log);
        chk1("save_wait", 1'b1, c == P_SEQ + P_SAVE);
        chk1("dirty_clr", 1'b0, dirty);
        nv_op(nvsram_host_pkg::OP_SAVE, c);
        chk1("clean_wait", 1'b1, c == P_SEQ);
    endtask
    task automatic t_restore();
        nv_op(nvsram_host_pkg::OP_RESTORE, c);
        chkw("rest_seq", nvsram_host_pkg::RESTORE_SEQ, seq_log);
        chk1("rest_wait", 1'b1, c == P_SEQ + P_RES);
        rd_chk(17'h0_0013, 8'hC3);
    endtask
    task automatic t_line();
        save_n <= 1'b0;
        repeat (10) @(posedge clk);
        chk1("line_busy", 1'b1, busy);
        chk1("line_ready", 1'b0, rdy);
        chk1("save_line_oe", 1'b0, hsb_oe);
        chk1("save_line_lvl", 1'b1, hsb_o);
        save_n <= 1'b1;
        send(nvsram_host_pkg::OP_WRITE, 17'h0_0020, 8'h96);
        rd_chk(17'h0_0020, 8'h96);
    endtask
    // mid-run reset: outputs go back to reset values, then a fresh boot wait
    task automatic t_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk1("rst_dirty", 1'b0, dirty);
        chk1("rst_busy", 1'b1, busy);
        chk1("rst_ready", 1'b0, rdy);
        chk1("rst_select", 1'b1, pins.ce_n);
        rst <= 1'b0;
        t_boot();
        rd_chk(17'h0_0020, 8'h96);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_boot();
        t_rw();
        t_save();
        t_restore();
        t_line();
        t_reset();
        conclude();
    end
endmodule // testbench
`default_nettype wire

// ### logic/nvsram_host.sv
// host-side controller for a byte-wide nvsram with soft save and restore
// assumes the memory pins are wired directly; dq and the save line are
// resolved outside from the enables, and one user command runs at a time
`default_nettype none

module nvsram_host #(
    parameter int unsigned POWERUP_CYC = nvsram_host_pkg::POWERUP_CYC,
    parameter int unsigned SAVE_CYC    = nvsram_host_pkg::SAVE_CYC,
    parameter int unsigned RESTORE_CYC = nvsram_host_pkg::RESTORE_CYC,
    parameter int unsigned SOFTSEQ_CYC = nvsram_host_pkg::SOFTSEQ_CYC
) (
    input  wire logic                              CLK_SYS_I,
    input  wire logic                              RST_I,
    // user command port
    input  wire logic                              CMD_VALID_I,
    input  wire nvsram_host_pkg::cmd_s             CMD_I,
    output var  logic                              CMD_READY_O,
    output var  logic [nvsram_host_pkg::DATA_W-1:0] RD_DATA_O,
    output var  logic                              RD_VALID_O,
    output var  logic                              NV_BUSY_O,
    output var  logic                              DIRTY_O,
    // memory pins
    output var  nvsram_host_pkg::mem_pins_s        MEM_O,
    input  wire logic [nvsram_host_pkg::DATA_W-1:0] MEM_DQ_I,
    input  wire logic                              HSB_N_I,
    output var  logic                              HSB_N_O,
    output var  logic                              HSB_N_OE_O
);

    // ------------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_BOOT,
        ST_IDLE,
        ST_ACCESS,
        ST_GAP,
        ST_NVWAIT
    } state_e;

    state_e                              state_reg;
    nvsram_host_pkg::cmd_s               cmd_reg;
    logic [nvsram_host_pkg::CNT_W-1:0]   cnt_reg;
    logic [nvsram_host_pkg::STEP_W-1:0]  step_reg;
    logic                                dirty_reg;
    logic [nvsram_host_pkg::DATA_W-1:0]  dq_s1_reg;
    logic [nvsram_host_pkg::DATA_W-1:0]  dq_s2_reg;
    logic [nvsram_host_pkg::DATA_W-1:0]  dq_s3_reg;
    logic [nvsram_host_pkg::DATA_W-1:0]  dq_stable_reg;
    logic                                hsb_s1_reg;
    logic                                hsb_s2_reg;
    logic                                hsb_s3_reg;
    logic                                hsb_high_reg;
    logic                                take;
    logic                                soft_op;
    logic [nvsram_host_pkg::ADDR_W-1:0]  seq_addr;
    nvsram_host_pkg::mem_pins_s          start_pins;
    logic [nvsram_host_pkg::CNT_W-1:0]   start_len;

    // ------------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------------
    // three flops; a level counts once the last two agree
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            dq_s1_reg     <= 8'h00;
            dq_s2_reg     <= 8'h00;
            dq_s3_reg     <= 8'h00;
            dq_stable_reg <= 8'h00;
        end else begin
            dq_s1_reg <= MEM_DQ_I;
            dq_s2_reg <= dq_s1_reg;
            dq_s3_reg <= dq_s2_reg;
            if (dq_s2_reg == dq_s3_reg) begin
                dq_stable_reg <= dq_s3_reg;
            end
        end
    end

    // save line sampled the same way; low means the device is saving
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            hsb_s1_reg   <= 1'b0;
            hsb_s2_reg   <= 1'b0;
            hsb_s3_reg   <= 1'b0;
            hsb_high_reg <= 1'b0;
        end else begin
            hsb_s1_reg <= HSB_N_I;
            hsb_s2_reg <= hsb_s1_reg;
            hsb_s3_reg <= hsb_s2_reg;
            if (hsb_s2_reg == hsb_s3_reg) begin
                hsb_high_reg <= hsb_s3_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // next access setup
    // ------------------------------------------------------------------
    assign take    = CMD_VALID_I && CMD_READY_O;
    assign soft_op = (cmd_reg.op == nvsram_host_pkg::OP_SAVE) ||
                     (cmd_reg.op == nvsram_host_pkg::OP_RESTORE);
    assign seq_addr = (cmd_reg.op == nvsram_host_pkg::OP_SAVE) ?
                      nvsram_host_pkg::STORE_SEQ[step_reg] :
                      nvsram_host_pkg::RESTORE_SEQ[step_reg];

    // pins for the first cycle of an access; reads use select-driven timing
    always_comb begin
        nvsram_host_pkg::cmd_s c;
        c          = take ? CMD_I : cmd_reg;
        start_pins = nvsram_host_pkg::PINS_IDLE;
        start_pins.ce_n = 1'b0;
        start_pins.addr = c.addr;
        if (c.op == nvsram_host_pkg::OP_WRITE) begin
            start_pins.we_n  = 1'b0;
            start_pins.dq    = c.wdata;
            start_pins.dq_oe = 1'b1;
            start_len = nvsram_host_pkg::CNT_W'(nvsram_host_pkg::WR_CYC - 1);
        end else begin
            start_pins.oe_n = 1'b0;
            start_len = nvsram_host_pkg::CNT_W'(nvsram_host_pkg::RD_CYC +
                                                nvsram_host_pkg::SYNC_CYC - 1);
        end
        if (!take && soft_op) begin
            start_pins.addr = seq_addr;
        end else if (take && c.op != nvsram_host_pkg::OP_READ &&
                     c.op != nvsram_host_pkg::OP_WRITE) begin
            start_pins.addr = (c.op == nvsram_host_pkg::OP_SAVE) ?
                              nvsram_host_pkg::STORE_SEQ[0] :
                              nvsram_host_pkg::RESTORE_SEQ[0];
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            state_reg   <= ST_BOOT;
            cmd_reg     <= '0;
            step_reg    <= 3'h0;
            MEM_O       <= nvsram_host_pkg::PINS_IDLE;
            CMD_READY_O <= 1'b0;
            RD_DATA_O   <= 8'h00;
            RD_VALID_O  <= 1'b0;
            cnt_reg     <= nvsram_host_pkg::CNT_W'(POWERUP_CYC - 1);
        end else begin
            RD_VALID_O <= 1'b0;
            case (state_reg)
                ST_BOOT: begin
                    if (cnt_reg == 22'h00_0000) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 22'h00_0001;
                    end
                end
                ST_IDLE: begin
                    CMD_READY_O <= hsb_high_reg && !take;
                    if (take) begin
                        cmd_reg   <= CMD_I;
                        step_reg  <= 3'h0;
                        MEM_O     <= start_pins;
                        cnt_reg   <= start_len;
                        state_reg <= ST_ACCESS;
                    end
                end
                ST_ACCESS: begin
                    if (cnt_reg == 22'h00_0000) begin
                        MEM_O     <= nvsram_host_pkg::PINS_IDLE;
                        cnt_reg   <= nvsram_host_pkg::CNT_W'(nvsram_host_pkg::GAP_CYC - 1);
                        state_reg <= ST_GAP;
                        if (cmd_reg.op == nvsram_host_pkg::OP_READ) begin
                            RD_DATA_O  <= dq_stable_reg;
                            RD_VALID_O <= 1'b1;
                        end
                    end else begin
                        cnt_reg <= cnt_reg - 22'h00_0001;
                    end
                end
                ST_GAP: begin
                    // short gap lets the device release dq before we drive it
                    if (cnt_reg != 22'h00_0000) begin
                        cnt_reg <= cnt_reg - 22'h00_0001;
                    end else if (soft_op && step_reg != nvsram_host_pkg::LAST_STEP) begin
                        step_reg  <= step_reg + 3'h1;
                        state_reg <= ST_ACCESS;
                        cnt_reg   <= start_len;
                        MEM_O     <= start_pins;
                        MEM_O.addr <= (cmd_reg.op == nvsram_host_pkg::OP_SAVE) ?
                                      nvsram_host_pkg::STORE_SEQ[step_reg + 3'h1] :
                                      nvsram_host_pkg::RESTORE_SEQ[step_reg + 3'h1];
                    end else if (soft_op) begin
                        state_reg <= ST_NVWAIT;
                        if (cmd_reg.op == nvsram_host_pkg::OP_RESTORE) begin
                            cnt_reg <= nvsram_host_pkg::CNT_W'(SOFTSEQ_CYC + RESTORE_CYC - 1);
                        end else if (dirty_reg) begin
                            cnt_reg <= nvsram_host_pkg::CNT_W'(SOFTSEQ_CYC + SAVE_CYC - 1);
                        end else begin
                            cnt_reg <= nvsram_host_pkg::CNT_W'(SOFTSEQ_CYC - 1);
                        end
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_NVWAIT: begin
                    // no access during save or restore
                    if (cnt_reg == 22'h00_0000) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 22'h00_0001;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    MEM_O     <= nvsram_host_pkg::PINS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // write tracking and status
    // ------------------------------------------------------------------
    // a write taken while a clean-up is due still marks dirty (set wins)
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            dirty_reg <= 1'b0;
        end else if (take && CMD_I.op == nvsram_host_pkg::OP_WRITE) begin
            dirty_reg <= 1'b1;
        end else if (state_reg == ST_GAP && soft_op && cnt_reg == 22'h00_0000 &&
                     step_reg == nvsram_host_pkg::LAST_STEP) begin
            dirty_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            NV_BUSY_O  <= 1'b1;
            DIRTY_O    <= 1'b0;
            HSB_N_O    <= 1'b1;
            HSB_N_OE_O <= 1'b0;
        end else begin
            NV_BUSY_O  <= (state_reg == ST_BOOT) || (state_reg == ST_NVWAIT) || !hsb_high_reg;
            DIRTY_O    <= dirty_reg;
            HSB_N_O    <= 1'b1;
            HSB_N_OE_O <= 1'b0;
        end
    end

endmodule // nvsram_host

`default_nettype wire

// ### logic/nvsram_host_pkg.sv
// constants, types and timing for the nvsram host controller
// assumes a 125 MHz system clock and the 45 ns speed grade of the memory
`default_nettype none

package nvsram_host_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 17;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W  = 22;
    localparam int unsigned STEP_W = 3;
    localparam int unsigned SEQ_LEN = 6;
    localparam logic [STEP_W-1:0] LAST_STEP = 3'h5;

    // ------------------------------------------------------------------
    // times and their cycle counts, rounded up so no wait is short
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ                    = 125;
    localparam int unsigned READ_CYCLE_TIME_NS         = 45;
    localparam int unsigned WRITE_CYCLE_TIME_NS        = 45;
    localparam int unsigned CE_RELEASE_TIME_NS         = 15;
    localparam int unsigned POWERUP_RESTORE_TIME_MS    = 20;
    localparam int unsigned SAVE_CYCLE_TIME_MS         = 15;
    localparam int unsigned SOFT_RESTORE_TIME_US       = 120;
    localparam int unsigned SOFT_SEQ_TIME_US           = 70;

    localparam int unsigned RD_CYC  = (READ_CYCLE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WR_CYC  = (WRITE_CYCLE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned GAP_CYC = (CE_RELEASE_TIME_NS * CLK_MHZ + 999) / 1000;
    // three sampling flops plus one cycle for the agree check
    localparam int unsigned SYNC_CYC = 4;
    localparam int unsigned POWERUP_CYC = POWERUP_RESTORE_TIME_MS * CLK_MHZ * 1000;
    localparam int unsigned SAVE_CYC    = SAVE_CYCLE_TIME_MS * CLK_MHZ * 1000;
    localparam int unsigned RESTORE_CYC = SOFT_RESTORE_TIME_US * CLK_MHZ;
    localparam int unsigned SOFTSEQ_CYC = SOFT_SEQ_TIME_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // soft command address sequences, read in order from index 0
    // ------------------------------------------------------------------
    localparam logic [SEQ_LEN-1:0][ADDR_W-1:0] STORE_SEQ = {
        17'h0_0F0F, 17'h0_F0F0, 17'h0_3C3C, 17'h0_C3C3, 17'h0_5A5A, 17'h0_A5A5};
    localparam logic [SEQ_LEN-1:0][ADDR_W-1:0] RESTORE_SEQ = {
        17'h0_1E1E, 17'h0_F0F0, 17'h0_3C3C, 17'h0_C3C3, 17'h0_5A5A, 17'h0_A5A5};

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_SAVE,
        OP_RESTORE
    } op_e;

    typedef struct packed {
        op_e               op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cmd_s;

    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic              dq_oe;
    } mem_pins_s;

    localparam mem_pins_s PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                        addr: 17'h0_0000, dq: 8'h00, dq_oe: 1'b0};

endpackage : nvsram_host_pkg

`default_nettype wire

// ### logic/README_unused.sv
// intentionally empty
`default_nettype none
`default_nettype wire
